//--- rtl/rtc_regs.vh
// register map, field positions, reset values and timing constants of the clock/calendar block
//
// Summary of operation
// RULE1 - host writes zero to fixed-zero control bits; unused bits ignored on read
// RULE2 - control one bit 7 selects external test clock driving the counter chain
// RULE3 - stop bit clears prescaler and halts timekeeping; 32.768 kHz output keeps running
// RULE4 - control one bit 3 is power reset override; zero in normal operation
// RULE5 - alarm match sets alarm flag, countdown end sets countdown flag; both sticky
// RULE6 - alarm flag reads back; writing zero clears it, writing one keeps it
// RULE7 - countdown flag reads back; written value is ANDed with the held flag
// RULE8 - alarm interrupt enable zero keeps alarm flag off the interrupt output
// RULE9 - countdown interrupt enable zero keeps countdown flag off the interrupt output
// RULE10 - interrupt output is OR of enabled alarm and countdown conditions
// RULE11 - level mode: interrupt active while countdown flag set and enabled
// RULE12 - pulse mode: each expiry gives a pulse whose width depends on source and count
// RULE13 - alarm flag with its enable always drives interrupt as a level
// RULE14 - in pulse mode countdown flag and pulse start in the same cycle; here the pulse starts one cycle before the flag bit goes high
// RULE15 - countdown value zero stops the countdown with no further expiries
// RULE16 - hours counter keeps BCD 00 to 23 in low six bits, upper two zero
// RULE17 - alarm field bit 7 set excludes that field from the alarm match
// RULE18 - internal reset clears all, sets flag, low-voltage, source, override, disable bits
// RULE19 - source select picks 4096, 64, 1 or 1/60 Hz; count reads back live
// RULE20 - interrupt pin is active-low open drain, released when nothing is active
// RULE21 - registers reached by word address; here over an APB slave
`ifndef RTC_REGS_VH
`define RTC_REGS_VH

// ****************************************
// register indices (byte address is index times four)
// ****************************************
`define IDX_CTRL_ONE      4'h0
`define IDX_CTRL_TWO      4'h1
`define IDX_SECONDS       4'h2
`define IDX_MINUTES       4'h3
`define IDX_HOURS         4'h4
`define IDX_DAY           4'h5
`define IDX_WEEKDAY       4'h6
`define IDX_MONTH         4'h7
`define IDX_YEAR          4'h8
`define IDX_MIN_MATCH     4'h9
`define IDX_HOUR_MATCH    4'ha
`define IDX_DAY_MATCH     4'hb
`define IDX_WDAY_MATCH    4'hc
`define IDX_SQWAVE        4'hd
`define IDX_CD_CTRL       4'he
`define IDX_CD_VALUE      4'hf
`define REG_IDX_LAST      6'h0f

// ****************************************
// field positions
// ****************************************
`define BIT_TEST_MODE     7
`define BIT_STOP          5
`define BIT_OVERRIDE      3
`define BIT_LEVEL_PULSE   4
`define BIT_ALARM_FLAG    3
`define BIT_CD_FLAG       2
`define BIT_ALARM_IE      1
`define BIT_CD_IE         0
`define BIT_LOW_VOLTAGE   7
`define BIT_FIELD_DIS     7
`define BIT_SQ_ENABLE     7
`define BIT_CD_ENABLE     7

// writable masks: fixed-zero and unused bits are dropped
`define MASK_CTRL_ONE     8'ha8
`define MASK_CTRL_TWO     8'h13
`define MASK_MINUTES      8'h7f
`define MASK_HOURS        8'h3f
`define MASK_DAY          8'h3f
`define MASK_WEEKDAY      8'h07
`define MASK_SEL          8'h83

// ****************************************
// reset values
// ****************************************
`define RST_CTRL_ONE      8'h08
`define RST_CTRL_TWO      8'h04
`define RST_SECONDS       8'h80
`define RST_MATCH         8'h80
`define RST_SQWAVE        8'h00
`define RST_CD_CTRL       8'h03
`define RST_ZERO          8'h00

// ****************************************
// source selections
// ****************************************
`define SRC_4096          2'h0
`define SRC_64            2'h1
`define SRC_1             2'h2
`define SRC_60TH          2'h3

// ****************************************
// timing, in oscillator ticks of 32768 Hz, plus the last seconds count and divider bit positions
// ****************************************
`define PW_TICKS_8192     10'h004
`define PW_TICKS_4096     10'h008
`define PW_TICKS_128      10'h100
`define PW_TICKS_64       10'h200
`define DIV_MASK_4096     15'h0007
`define DIV_MASK_64       15'h01ff
`define DIV_MASK_1        15'h7fff
`define SECS_PER_MIN_LAST 6'h3b
`define SQ_BIT_1024       4
`define SQ_BIT_32         9
`define SQ_BIT_1          14

`endif

//--- rtl/rtc_byte_store.v
// small byte store for the plain calendar registers, registered read
`timescale 1ns/10ps
`include "rtc_regs.vh"
module rtc_byte_store (
  input  wire       clk,
  input  wire       rst,
  input  wire       ce,
  input  wire       wr_en,
  input  wire [1:0] wr_addr,
  input  wire [7:0] wr_data,
  input  wire [1:0] rd_addr,
  output reg  [7:0] rd_data_q
);
  reg [7:0] mem_q [0:3];
  genvar    g;

  // ****************************************
  // storage words, reset to their image
  // ****************************************
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_word
      always @(posedge clk) begin
        if (rst) begin
          mem_q[g] <= (g == 0) ? `RST_SECONDS : `RST_ZERO; // RULE18
        end else if (ce && wr_en && wr_addr == g) begin
          mem_q[g] <= wr_data;
        end
      end
    end
  endgenerate

  // registered read port
  always @(posedge clk) begin
    if (rst) begin
      rd_data_q <= `RST_ZERO;
    end else if (ce) begin
      rd_data_q <= mem_q[rd_addr];
    end
  end
endmodule

//--- rtl/rtc_ctrl_status.v
// control, status, countdown and interrupt logic of the clock/calendar block
`timescale 1ns/10ps
`include "rtc_regs.vh"
module rtc_ctrl_status #(
  parameter OSC_STOP_CYCLES = 12288
) (
  input  wire        clk,
  input  wire        rst,
  input  wire        ce,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        osc_in,
  input  wire        external_test_clock,
  output wire        irq_out,
  output wire        irq_oe_n,
  output reg         square_wave_q,
  output wire        square_wave_oe_n,
  output wire        internal_reset
);

  // ****************************************
  // functions
  // ****************************************
  // one alarm field: disabled fields always match
  function field_match;
    input [7:0] alarm;
    input [7:0] cur;
    input [7:0] mask;
    begin
      field_match = alarm[`BIT_FIELD_DIS] | ((alarm & mask) == (cur & mask)); // RULE17
    end
  endfunction

  // maps a register index onto the byte store word, flags store membership
  function [2:0] store_slot;
    input [3:0] idx;
    begin
      case (idx)
        `IDX_SECONDS: store_slot = 3'h4;
        `IDX_MONTH:   store_slot = 3'h5;
        `IDX_YEAR:    store_slot = 3'h6;
        default:      store_slot = 3'h0;
      endcase
    end
  endfunction

  // ****************************************
  // declarations
  // ****************************************
  reg  [7:0]  ctrl_one_q;
  reg  [7:0]  ctrl_two_q;
  reg  [7:0]  minutes_q;
  reg  [7:0]  hours_q;
  reg  [7:0]  day_q;
  reg  [7:0]  weekday_q;
  reg  [7:0]  match_q [0:3];
  reg  [7:0]  sqwave_q;
  reg  [7:0]  cd_ctrl_q;
  reg  [7:0]  cd_reload_q;
  reg  [7:0]  cd_count_q;
  reg  [14:0] div_q;
  reg  [5:0]  sec_cnt_q;
  reg  [9:0]  pulse_q;
  reg  [9:0]  pulse_width;
  reg         match_prev_q;
  reg  [2:0]  osc_sync_q;
  reg  [2:0]  ext_sync_q;
  reg  [15:0] stop_cnt_q;
  reg         rd_done_q;
  reg         rd_from_store_q;
  reg  [7:0]  rd_byte_q;
  reg  [7:0]  rd_byte_d;
  wire [7:0]  store_rdata;
  wire [5:0]  idx_full;
  wire [3:0]  idx;
  wire        mapped;
  wire        wr_acc;
  wire        rd_acc;
  wire        osc_tick;
  wire        chain_tick;
  wire        tick_4096;
  wire        tick_64;
  wire        tick_1;
  wire        tick_60th;
  wire        src_tick;
  wire        cd_expire;
  wire        alarm_match;
  wire        alarm_event;
  wire        irq_active;
  wire [2:0]  slot;
  wire        osc_stopped;
  wire        iclr;
  genvar      g;

  // ****************************************
  // apb decode
  // ****************************************
  assign idx_full = paddr[7:2];
  assign idx      = paddr[5:2];
  assign mapped   = (idx_full <= `REG_IDX_LAST) && (paddr[1:0] == 2'h0); // RULE21
  assign wr_acc   = ce && psel && penable && pwrite && mapped;
  assign rd_acc   = ce && psel && penable && !pwrite && !rd_done_q;
  assign slot     = store_slot(idx);
  // writes answer at once, reads one cycle later from flops
  assign pready   = psel && penable && ((pwrite && ce) || rd_done_q);
  assign pslverr  = pready && !mapped;
  assign prdata   = {24'h000000, rd_from_store_q ? store_rdata : rd_byte_q};

  // read mux of the registers held here; unused bits read zero except in the hour, day and weekday match registers
  always @* begin
    rd_byte_d = `RST_ZERO;
    case (idx)
      `IDX_CTRL_ONE:   rd_byte_d = ctrl_one_q;
      `IDX_CTRL_TWO:   rd_byte_d = ctrl_two_q; // RULE6 RULE7
      `IDX_MINUTES:    rd_byte_d = minutes_q;
      `IDX_HOURS:      rd_byte_d = hours_q;
      `IDX_DAY:        rd_byte_d = day_q;
      `IDX_WEEKDAY:    rd_byte_d = weekday_q;
      `IDX_MIN_MATCH:  rd_byte_d = match_q[0];
      `IDX_HOUR_MATCH: rd_byte_d = match_q[1];
      `IDX_DAY_MATCH:  rd_byte_d = match_q[2];
      `IDX_WDAY_MATCH: rd_byte_d = match_q[3];
      `IDX_SQWAVE:     rd_byte_d = sqwave_q;
      `IDX_CD_CTRL:    rd_byte_d = cd_ctrl_q;
      `IDX_CD_VALUE:   rd_byte_d = cd_count_q; // RULE19
      default:         rd_byte_d = `RST_ZERO;
    endcase
    if (!mapped) begin
      rd_byte_d = `RST_ZERO;
    end
  end

  // read answer flops
  always @(posedge clk) begin
    if (iclr) begin
      rd_done_q       <= 1'b0;
      rd_from_store_q <= 1'b0;
      rd_byte_q       <= `RST_ZERO;
    end else if (ce) begin
      rd_done_q       <= rd_acc;
      if (rd_acc) begin
        rd_from_store_q <= slot[2] && mapped;
        rd_byte_q       <= rd_byte_d;
      end
    end
  end

  // seconds, month and year live in the byte store
  rtc_byte_store u_store (
    .clk       (clk),
    .rst       (iclr),
    .ce        (ce),
    .wr_en     (wr_acc && slot[2]),
    .wr_addr   (slot[1:0]),
    .wr_data   (pwdata[7:0]),
    .rd_addr   (slot[1:0]),
    .rd_data_q (store_rdata)
  );

  // ****************************************
  // pin synchronisers and oscillator watch
  // ****************************************
  // two flops before use; the third only delays for edge detection
  always @(posedge clk) begin
    if (rst) begin
      osc_sync_q <= 3'h0;
      ext_sync_q <= 3'h0;
    end else if (ce) begin
      osc_sync_q <= {osc_sync_q[1:0], osc_in};
      ext_sync_q <= {ext_sync_q[1:0], external_test_clock};
    end
  end

  assign osc_tick   = osc_sync_q[1] && !osc_sync_q[2];
  assign chain_tick = ctrl_one_q[`BIT_TEST_MODE] ? (ext_sync_q[1] && !ext_sync_q[2]) // RULE2
                                                 : osc_tick;

  // counts clk cycles since the last rising oscillator edge
  always @(posedge clk) begin
    if (rst || osc_tick) begin
      stop_cnt_q <= 16'h0000;
    end else if (ce && !osc_stopped) begin
      stop_cnt_q <= stop_cnt_q + 16'h0001;
    end
  end

  assign osc_stopped    = (stop_cnt_q >= OSC_STOP_CYCLES[15:0]);
  assign internal_reset = osc_stopped && ctrl_one_q[`BIT_OVERRIDE]; // RULE4
  assign iclr           = rst || (ce && internal_reset);

  // ****************************************
  // prescaler chain
  // ****************************************
  // stop clears the divider at once and holds it
  always @(posedge clk) begin
    if (iclr || ctrl_one_q[`BIT_STOP]) begin
      div_q     <= 15'h0000; // RULE3
      sec_cnt_q <= 6'h00;
    end else if (ce && chain_tick) begin
      div_q <= div_q + 15'h0001;
      if (tick_1) begin
        sec_cnt_q <= (sec_cnt_q == `SECS_PER_MIN_LAST) ? 6'h00 : sec_cnt_q + 6'h01;
      end
    end
  end

  assign tick_4096 = chain_tick && ((div_q & `DIV_MASK_4096) == `DIV_MASK_4096);
  assign tick_64   = chain_tick && ((div_q & `DIV_MASK_64) == `DIV_MASK_64);
  assign tick_1    = chain_tick && (div_q == `DIV_MASK_1);
  assign tick_60th = tick_1 && (sec_cnt_q == `SECS_PER_MIN_LAST);

  // ****************************************
  // register writes
  // ****************************************
  always @(posedge clk) begin
    if (iclr) begin
      ctrl_one_q  <= `RST_CTRL_ONE; // RULE18
      minutes_q   <= `RST_ZERO;
      hours_q     <= `RST_ZERO;
      day_q       <= `RST_ZERO;
      weekday_q   <= `RST_ZERO;
      sqwave_q    <= `RST_SQWAVE;
      cd_ctrl_q   <= `RST_CD_CTRL;
      cd_reload_q <= `RST_ZERO;
    end else if (wr_acc) begin
      case (idx)
        `IDX_CTRL_ONE: ctrl_one_q  <= pwdata[7:0] & `MASK_CTRL_ONE; // RULE1
        `IDX_MINUTES:  minutes_q   <= pwdata[7:0] & `MASK_MINUTES;
        `IDX_HOURS:    hours_q     <= pwdata[7:0] & `MASK_HOURS; // RULE16
        `IDX_DAY:      day_q       <= pwdata[7:0] & `MASK_DAY;
        `IDX_WEEKDAY:  weekday_q   <= pwdata[7:0] & `MASK_WEEKDAY;
        `IDX_SQWAVE:   sqwave_q    <= pwdata[7:0] & `MASK_SEL;
        `IDX_CD_CTRL:  cd_ctrl_q   <= pwdata[7:0] & `MASK_SEL;
        `IDX_CD_VALUE: cd_reload_q <= pwdata[7:0];
        default:       ctrl_one_q  <= ctrl_one_q;
      endcase
    end
  end

  // alarm match registers, disable bit set at reset
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_match
      always @(posedge clk) begin
        if (iclr) begin
          match_q[g] <= `RST_MATCH; // RULE18
        end else if (wr_acc && idx == (`IDX_MIN_MATCH + g)) begin
          match_q[g] <= pwdata[7:0];
        end
      end
    end
  endgenerate

  // ****************************************
  // countdown
  // ****************************************
  assign src_tick = (cd_ctrl_q[1:0] == `SRC_4096) ? tick_4096 : // RULE19
                    (cd_ctrl_q[1:0] == `SRC_64)   ? tick_64   :
                    (cd_ctrl_q[1:0] == `SRC_1)    ? tick_1    : tick_60th;

  // a zero count never expires
  assign cd_expire = ce && cd_ctrl_q[`BIT_CD_ENABLE] && src_tick
                     && (cd_count_q == 8'h01) && !(wr_acc && idx == `IDX_CD_VALUE); // RULE15

  // live count: loaded by the host, reloaded at each expiry
  always @(posedge clk) begin
    if (iclr) begin
      cd_count_q <= `RST_ZERO;
    end else if (wr_acc && idx == `IDX_CD_VALUE) begin
      cd_count_q <= pwdata[7:0];
    end else if (cd_expire) begin
      cd_count_q <= cd_reload_q;
    end else if (ce && cd_ctrl_q[`BIT_CD_ENABLE] && src_tick && cd_count_q != 8'h00) begin
      cd_count_q <= cd_count_q - 8'h01; // RULE15
    end
  end

  // pulse width from the source and the loaded count
  always @* begin
    case (cd_ctrl_q[1:0])
      `SRC_4096: pulse_width = (cd_reload_q == 8'h01) ? `PW_TICKS_8192 : `PW_TICKS_4096;
      `SRC_64:   pulse_width = (cd_reload_q == 8'h01) ? `PW_TICKS_128 : `PW_TICKS_64;
      default:   pulse_width = `PW_TICKS_64;
    endcase
  end

  // pulse timer, counted in oscillator ticks
  always @(posedge clk) begin
    if (iclr) begin
      pulse_q <= 10'h000;
    end else if (cd_expire) begin
      pulse_q <= pulse_width; // RULE12
    end else if (ce && osc_tick && pulse_q != 10'h000) begin
      pulse_q <= pulse_q - 10'h001;
    end
  end

  // ****************************************
  // alarm and flags
  // ****************************************
  assign alarm_match = field_match(match_q[0], minutes_q, `MASK_MINUTES)
                     & field_match(match_q[1], hours_q, `MASK_HOURS)
                     & field_match(match_q[2], day_q, `MASK_DAY)
                     & field_match(match_q[3], weekday_q, `MASK_WEEKDAY)
                     & ~(match_q[0][7] & match_q[1][7] & match_q[2][7] & match_q[3][7]);
  assign alarm_event = ce && alarm_match && !match_prev_q;

  // remembers the match so one match sets the flag once
  always @(posedge clk) begin
    if (iclr) begin
      match_prev_q <= 1'b0;
    end else if (ce) begin
      match_prev_q <= alarm_match;
    end
  end

  // flags: set wins over a clearing write in the same cycle
  always @(posedge clk) begin
    if (iclr) begin
      ctrl_two_q <= `RST_CTRL_TWO; // RULE18
    end else begin
      if (wr_acc && idx == `IDX_CTRL_TWO) begin
        ctrl_two_q[`BIT_LEVEL_PULSE] <= pwdata[`BIT_LEVEL_PULSE];
        ctrl_two_q[`BIT_ALARM_IE]    <= pwdata[`BIT_ALARM_IE];
        ctrl_two_q[`BIT_CD_IE]       <= pwdata[`BIT_CD_IE];
        ctrl_two_q[`BIT_ALARM_FLAG]  <= alarm_event
          | (ctrl_two_q[`BIT_ALARM_FLAG] & pwdata[`BIT_ALARM_FLAG]); // RULE6
        ctrl_two_q[`BIT_CD_FLAG]     <= cd_expire
          | (ctrl_two_q[`BIT_CD_FLAG] & pwdata[`BIT_CD_FLAG]); // RULE7
      end else begin
        if (alarm_event) begin
          ctrl_two_q[`BIT_ALARM_FLAG] <= 1'b1; // RULE5
        end
        if (cd_expire) begin
          ctrl_two_q[`BIT_CD_FLAG] <= 1'b1; // RULE5 RULE14
        end
      end
    end
  end

  // ****************************************
  // interrupt and square wave pins
  // ****************************************
  assign irq_active = (ctrl_two_q[`BIT_ALARM_FLAG] & ctrl_two_q[`BIT_ALARM_IE]) // RULE8 RULE13
                    | (ctrl_two_q[`BIT_CD_IE] // RULE9 RULE10
                       & (ctrl_two_q[`BIT_LEVEL_PULSE] ? (cd_expire | (pulse_q != 10'h000)) // RULE14
                                                       : ctrl_two_q[`BIT_CD_FLAG])); // RULE11
  assign irq_out  = 1'b0;
  assign irq_oe_n = ~irq_active; // RULE20

  // square wave: 32.768 kHz runs even while stopped
  always @(posedge clk) begin
    if (iclr) begin
      square_wave_q <= 1'b0;
    end else if (ce) begin
      case (sqwave_q[1:0])
        2'h0:    square_wave_q <= osc_sync_q[1]; // RULE3
        2'h1:    square_wave_q <= div_q[`SQ_BIT_1024];
        2'h2:    square_wave_q <= div_q[`SQ_BIT_32];
        default: square_wave_q <= div_q[`SQ_BIT_1];
      endcase
    end
  end

  // open drain: pulls low only while enabled and the wave is low
  assign square_wave_oe_n = ~(sqwave_q[`BIT_SQ_ENABLE] & ~square_wave_q);
endmodule

//--- tb/rtc_ctrl_checker_assertions.sv
// port assertions for the control, status and interrupt block
`timescale 1ns/10ps
module rtc_ctrl_checker #(
  parameter OSC_STOP_CYCLES = 12288
) (
  input wire        clk,
  input wire        rst,
  input wire        ce,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        osc_in,
  input wire        irq_out,
  input wire        irq_oe_n,
  input wire        square_wave_oe_n,
  input wire        internal_reset
);
  reg        osc_d_q;
  reg [15:0] quiet_q;
  default clocking dck @(posedge clk);
  endclocking
  default disable iff (rst);
  // ***************
  // helper logic
  // ***************
  // cycles since the oscillator pin last moved
  always @(posedge clk) begin
    osc_d_q <= osc_in;
    if (rst || osc_in != osc_d_q)
      quiet_q <= 16'h0000;
    else if (quiet_q != 16'hffff)
      quiet_q <= quiet_q + 16'h0001;
  end
  // ***************
  // checks
  // ***************
  AST_WR_NO_WAIT: assert property (psel && penable && pwrite && ce |-> pready)
    else $error("write not answered in first access cycle");
  AST_RD_ONE_WAIT: assert property (
    psel && penable && !pwrite && ce && !$past(penable) |-> !pready ##1 pready)
    else $error("read not answered after one wait state");
  AST_IDLE_NO_READY: assert property (!(psel && penable) |-> !pready)
    else $error("ready outside an access phase");
  AST_BAD_ADDR_ERR: assert property (
    pready && (paddr[1:0] != 2'h0 || paddr[7:6] != 2'h0) |-> pslverr)
    else $error("unmapped access without error");
  AST_GOOD_ADDR_OK: assert property (
    pready && paddr[1:0] == 2'h0 && paddr[7:6] == 2'h0 |-> !pslverr)
    else $error("mapped access flagged as error");
  AST_ERR_READ_ZERO: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  AST_UPPER_ZERO: assert property (pready && !pwrite |-> prdata[31:8] == 24'h000000)
    else $error("unused read bits not zero");
  AST_LEVEL_IRQ: assert property (
    pready && !pwrite && paddr == 8'h04 && prdata[2] && prdata[0] && !prdata[4] |-> !irq_oe_n)
    else $error("level interrupt not driven while flag and enable read set");
  AST_IRQ_OPEN_DRAIN: assert property (irq_out == 1'b0)
    else $error("interrupt pin value not low");
  AST_RESET_RELEASE: assert property (disable iff (1'b0) rst |=> irq_oe_n && square_wave_oe_n)
    else $error("pins not released after reset");
  AST_INT_RESET_CAUSE: assert property (
    $rose(internal_reset) |-> quiet_q >= OSC_STOP_CYCLES / 2)
    else $error("internal reset while oscillator runs");
endmodule
bind rtc_ctrl_status rtc_ctrl_checker #(.OSC_STOP_CYCLES(OSC_STOP_CYCLES)) rtc_ctrl_checker_inst (
  .clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .osc_in(osc_in),
  .irq_out(irq_out), .irq_oe_n(irq_oe_n), .square_wave_oe_n(square_wave_oe_n),
  .internal_reset(internal_reset));

//--- tb/rtc_host_model.sv
// host model: apb master reaching the registers by word index
`timescale 1ns/10ps
module rtc_host_model (
  input  wire         clk,
  output logic        psel,
  output logic        penable,
  output logic        pwrite,
  output logic [7:0]  paddr,
  output logic [31:0] pwdata,
  input  wire  [31:0] prdata,
  input  wire         pready,
  input  wire         pslverr
);
  // bus idle at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // one transfer; request held until ready is seen high or 64 cycles pass
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
                      output logic [31:0] rd, output logic err);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    rd = prdata;
    err = (pready === 1'b1) ? pslverr : 1'bx;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= {24'hffffff, ~d};
    @(negedge clk);
  endtask
  // register write; fixed-zero control bits always sent as zero
  task automatic reg_wr(input logic [3:0] idx, input logic [7:0] d);
    logic [31:0] rd;
    logic        err;
    logic [7:0]  v;
    v = (idx == 4'h0) ? (d & 8'ha8) : (idx == 4'h1) ? (d & 8'h1f) : d;
    xfer(1'b1, {2'h0, idx, 2'h0}, v, rd, err);
  endtask
endmodule

//--- tb/testbench.sv
// self-checking bench for the control, status and interrupt block
`timescale 1ns/10ps
module testbench;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        osc_in = 1'b0;
  logic        osc_run = 1'b1;
  logic [2:0]  osc_div = 3'h0;
  wire         psel, penable, pwrite, pready, pslverr;
  wire  [7:0]  paddr;
  wire  [31:0] pwdata, prdata;
  wire         irq_out, irq_oe_n, sq_q, sq_oe_n, int_rst;
  int          err_count = 0;
  int          n_compared = 0;
  int          cyc = 0;
  logic [7:0]  mdl [16];
  // ***************
  // clocks, timeout and instances
  // ***************
  always #5 clk = ~clk;
  // oscillator pin: one tick every 16 clk cycles
  always @(posedge clk) begin
    osc_div <= osc_div + 3'h1;
    if (osc_run && osc_div == 3'h7)
      osc_in <= ~osc_in;
  end
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      final_report();
    end
  end
  rtc_ctrl_status #(.OSC_STOP_CYCLES(64)) rtc_ctrl_status_inst (
    .clk(clk), .rst(rst), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .osc_in(osc_in), .external_test_clock(osc_div[2]), .irq_out(irq_out), .irq_oe_n(irq_oe_n),
    .square_wave_q(sq_q), .square_wave_oe_n(sq_oe_n), .internal_reset(int_rst));
  rtc_host_model rtc_host_model_inst (
    .clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // ***************
  // tasks
  // ***************
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", name, exp, got);
      err_count++;
    end
  endtask
  task automatic wr(input logic [3:0] i, input logic [7:0] d);
    rtc_host_model_inst.reg_wr(i, d);
  endtask
  task automatic rd(input logic [3:0] i, input logic [7:0] exp);
    logic [31:0] v;
    logic        e;
    rtc_host_model_inst.xfer(1'b0, {2'h0, i, 2'h0}, 8'h00, v, e);
    chk($sformatf("reg %0h", i), {24'h0, exp}, v);
    chk("read error", 32'h0, {31'h0, e});
  endtask
  // wait for the pin to go low, then time the low phase up to maxw cycles
  task automatic irq_low(input int limit, input int maxw, output int w);
    int n;
    n = 0;
    w = 0;
    while (irq_oe_n !== 1'b0 && n < limit) begin
      @(negedge clk);
      n++;
    end
    while (irq_oe_n === 1'b0 && w < maxw) begin
      @(negedge clk);
      w++;
    end
  endtask
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ***************
  // main sequence
  // ***************
  initial begin
    int          w, k, tg;
    logic        last, e;
    logic [7:0]  d;
    logic [31:0] v;
    logic [3:0]  ridx [7] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'hd, 4'hf};
    logic [7:0]  rmsk [7] = '{8'h7f, 8'h3f, 8'h3f, 8'h07, 8'hff, 8'h83, 8'hff};
    void'($urandom(32'h0055c609));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    mdl = '{8'h08, 8'h04, 8'h80, 0, 0, 0, 0, 0, 0, 8'h80, 8'h80, 8'h80, 8'h80, 0, 8'h03, 0};
    for (int i = 0; i < 16; i++) rd(i[3:0], mdl[i]);
    chk("flag without enable", 32'h1, {31'h0, irq_oe_n});
    // refused accesses
    rtc_host_model_inst.xfer(1'b0, 8'h40, 8'h00, v, e);
    chk("unmapped data", 32'h0, v);
    rtc_host_model_inst.xfer(1'b1, 8'h0d, 8'h55, v, e);
    chk("unaligned error", 32'h1, {31'h0, e});
    rd(4'h3, 8'h00);
    wr(4'h0, 8'h00);
    rd(4'h0, 8'h00);
    // random writes and read back against the model
    for (int i = 0; i < 20; i++) begin
      k = $urandom_range(6);
      d = $urandom;
      wr(ridx[k], d);
      mdl[ridx[k]] = d & rmsk[k];
      rd(ridx[k], mdl[ridx[k]]);
    end
    // level interrupt from the countdown flag
    wr(4'h1, 8'h05);
    chk("level irq", 32'h0, {31'h0, irq_oe_n});
    wr(4'h1, 8'h01);
    rd(4'h1, 8'h01);
    chk("flag cleared", 32'h1, {31'h0, irq_oe_n});
    wr(4'hf, 8'h01);
    wr(4'he, 8'h80);
    irq_low(400, 80, w);
    rd(4'h1, 8'h05);
    // pulse mode, count one then count two
    wr(4'h1, 8'h11);
    irq_low(400, 300, w);
    chk("pulse n1", 32'h1, {31'h0, w >= 60 && w <= 68});
    rd(4'h1, 8'h15);
    wr(4'he, 8'h00);
    wr(4'hf, 8'h02);
    wr(4'he, 8'h80);
    irq_low(600, 300, w);
    chk("pulse n2", 32'h1, {31'h0, w >= 124 && w <= 132});
    // zero count stops expiries
    wr(4'hf, 8'h00);
    wr(4'h1, 8'h11);
    repeat (500) @(negedge clk);
    rd(4'h1, 8'h11);
    // stop bit halts the countdown, wave keeps running
    wr(4'hd, 8'h80);
    wr(4'h0, 8'h20);
    wr(4'hf, 8'h01);
    tg = 0;
    last = sq_oe_n;
    repeat (400) begin
      @(negedge clk);
      tg += (sq_oe_n !== last);
      last = sq_oe_n;
    end
    chk("wave toggles", 32'h1, {31'h0, tg > 40});
    rd(4'h1, 8'h11);
    wr(4'h0, 8'h00);
    irq_low(400, 300, w);
    chk("restart", 32'h1, {31'h0, w > 0});
    // alarm flag, its enable and clear by zero
    wr(4'he, 8'h03);
    wr(4'h1, 8'h00);
    wr(4'h3, 8'h12);
    wr(4'h9, 8'h12);
    chk("alarm masked", 32'h1, {31'h0, irq_oe_n});
    rd(4'h1, 8'h08);
    wr(4'h1, 8'h1a);
    chk("alarm level", 32'h0, {31'h0, irq_oe_n});
    wr(4'h1, 8'h12);
    wr(4'h1, 8'h1a);
    rd(4'h1, 8'h12);
    chk("alarm cleared", 32'h1, {31'h0, irq_oe_n});
    // test clock runs the chain while the oscillator is held, then stop with override set
    wr(4'h0, 8'h80);
    osc_run <= 1'b0;
    wr(4'he, 8'h80);
    repeat (100) @(negedge clk);
    rd(4'h1, 8'h16);
    wr(4'h0, 8'h08);
    osc_run <= 1'b0;
    repeat (100) @(negedge clk);
    chk("internal reset", 32'h1, {31'h0, int_rst});
    osc_run <= 1'b1;
    repeat (40) @(posedge clk);
    rd(4'h3, 8'h00);
    rd(4'h1, 8'h04);
    final_report();
  end
endmodule
